// [clk_source.sv]
// Far-side model: the crystal, RC network or clock source on the clock-in pin.
// Assumes the bench chooses the half period and when the source runs.
module clk_source (
  input  wire logic        run,
  input  wire logic [15:0] half_ns,
  output logic             clk_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Free-running source; it holds its level while stopped
  initial begin
    clk_o = 1'b0;
    forever begin
      // A zero half period would hang the simulator, so it falls back to 100 ns
      #((half_ns == 16'h0000) ? 100 : half_ns);
      clk_o = run ? !clk_o : clk_o;
    end
  end
endmodule

// [div_if.sv]
// Carrier between the top module and an edge divider: level in, count back.
// Assumes both ends run on the same clock.
interface div_if #(parameter int W = 2);
  logic         level;
  logic [W-1:0] count;
  modport src (output level, input count);
  modport div (input level, output count);
endinterface

// [edge_divider.sv]
// Counts rising edges of a level; count bit k is the level divided by 2^(k+1).
// Assumes the level comes from a flip-flop on the same clock.
module edge_divider #(
  parameter int W = 2
) (
  input  wire logic clk,
  input  wire logic rst_n,
  div_if.div        d
);

  typedef struct packed {
    logic         prev;
    logic [W-1:0] cnt;
  } div_state_t;

  div_state_t s_q;
  div_state_t s_d;

  always_comb begin
    s_d      = s_q;
    s_d.prev = d.level;
    if (d.level && !s_q.prev) begin
      s_d.cnt = s_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign d.count = s_q.cnt;

endmodule

// [osc_control.sv]
// Oscillator mode decode, internal oscillator block and pin reuse, AHB-Lite slave.
// Assumes one clock MCLK; oscillators are modelled as levels sampled on MCLK.
//
// How it works
// - Crystal PLL mode multiplies input by four
// - PLL enabled only in crystal PLL mode
// - External clock modes need no start delay
// - External clock mode drives Fosc/4 out
// - External clock reuse mode: out pin bit six
// - RC mode drives Fosc/4 on out pin
// - RC reuse mode: out pin is bit six
// - Fast oscillator 8 MHz, postscaler 125k-4M
// - Fast oscillator on for 125k-8M selections
// - Slow oscillator gives nominal 31 kHz
// - Slow on for internal source or features
// - Frequency select picks direct or postscaled
// - Internal clock-out: Fosc/4 out, in pin bit seven
// - Internal dual mode: both pins port bits
// - Slow retunes within eight own cycles
// - Fast retunes within one millisecond
// - No settle flag, execution continues
// - Tune code two's complement around center
// - Every tune step equal size
// - Select codes 111 fast, 000 slow
// - Four config bits pick ten modes
`include "osc_map.svh"

module osc_control
  import osc_pkg::*;
#(
  parameter int unsigned SLOW_SETTLE_CYC =
    (`OSC_SLOW_CYCLES * `OSC_SLOW_CYCLE_NS) / `OSC_MCLK_NS,
  parameter int unsigned FAST_SETTLE_CYC = `OSC_FAST_SETTLE_NS / `OSC_MCLK_NS
) (
  input  wire logic        MCLK,
  input  wire logic        RST_N,
  input  wire logic [3:0]  OSC_MODE_CFG,
  input  wire logic        PWRT_EN,
  input  wire logic        FSCM_EN,
  input  wire logic        WDT_EN,
  input  wire logic        TWO_SPEED_EN,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  input  wire logic        CLKIN_I,
  output logic             CLKIN_O,
  output logic             CLKIN_OE_N,
  input  wire logic        CLKOUT_I,
  output logic             CLKOUT_O,
  output logic             CLKOUT_OE_N,
  input  wire logic        PA6_OUT,
  input  wire logic        PA6_OE,
  output logic             PA6_IN,
  input  wire logic        PA7_OUT,
  input  wire logic        PA7_OE,
  output logic             PA7_IN,
  output logic             SYS_CLK,
  output logic             PLL_EN,
  output logic             START_DELAY_EN,
  output logic             FAST_OSC_EN,
  output logic             SLOW_OSC_EN
);

  // ==========================================================================
  // State and helpers
  ctl_state_t  q;
  ctl_state_t  d;
  logic [1:0]  pin_s;
  logic        int_mode;
  logic        nco_run;
  logic        slow_clk;
  logic        int_clk;
  logic        pin_clk;
  logic        fosc4;
  logic [7:0]  half;
  logic [31:0] inc;
  logic [31:0] tune_ext;
  logic [32:0] acc_sum;
  logic        addr_ok;

  div_if #(.W(`OSC_POST_W))     post_bus ();
  div_if #(.W(`OSC_FOSC_DIV_W)) fosc_bus ();

  // ==========================================================================
  // Pin synchronisers and dividers
  pin_sync #(.W(2)) u_pins (
    .clk     (MCLK),
    .rst_n   (RST_N),
    .async_i ({CLKOUT_I, CLKIN_I}),
    .sync_o  (pin_s)
  );

  edge_divider #(.W(`OSC_POST_W)) u_post (
    .clk   (MCLK),
    .rst_n (RST_N),
    .d     (post_bus)
  );

  edge_divider #(.W(`OSC_FOSC_DIV_W)) u_fosc (
    .clk   (MCLK),
    .rst_n (RST_N),
    .d     (fosc_bus)
  );

  assign post_bus.level = q.fast_clk;
  assign fosc_bus.level = q.sys_clk;
  assign slow_clk       = post_bus.count[`OSC_POST_W-1];
  assign fosc4          = fosc_bus.count[`OSC_FOSC_DIV_W-1];
  assign pin_clk        = pin_s[0];
  assign int_mode       = (q.mode == MODE_INT_CLKOUT) || (q.mode == MODE_INT_DUAL);
  assign nco_run        = q.fast_en || q.slow_en;
  assign addr_ok        = HSEL && HTRANS[1] && HREADY;

  // Signed tune code scales one fixed step, so the span is linear around center
  assign tune_ext = {{(32-`OSC_TUNE_W){q.tune_app[`OSC_TUNE_W-1]}}, q.tune_app};
  assign inc      = `OSC_NCO_BASE + tune_ext * `OSC_NCO_STEP;
  assign acc_sum  = {1'b0, q.acc} + {1'b0, inc};
  assign half     = (q.per >= 8'h02 * `OSC_PLL_MULT) ?
                    (q.per - 8'h02 * `OSC_PLL_MULT + 8'h01) : 8'h00;

  // ==========================================================================
  // Next state
  always_comb begin
    d = q;

    // Bus slave: capture address phase, apply write in data phase
    d.wr_tune = addr_ok && HWRITE && (HADDR == `OSC_REG_TUNE);
    d.wr_ctrl = addr_ok && HWRITE && (HADDR == `OSC_REG_CTRL);
    if (q.wr_tune) begin
      d.tune = HWDATA[`OSC_TUNE_W-1:0];
    end
    if (q.wr_ctrl) begin
      d.ifs = HWDATA[`OSC_CTRL_IFS_LSB +: 3];
    end
    if (addr_ok && !HWRITE) begin
      if (HADDR == `OSC_REG_TUNE) begin
        d.rdata = {26'h0, q.tune};
      end else if (HADDR == `OSC_REG_CTRL) begin
        d.rdata = {25'h0, q.ifs, 4'h0};
      end else if (HADDR == `OSC_REG_STAT) begin
        // Only the mode and the enables are reported; a tune shift has no completion bit
        d.rdata = {24'h0, q.start_dly, q.slow_en, q.fast_en, q.pll_en, q.mode};
      end else begin
        d.rdata = 32'h0;
      end
    end else begin
      d.rdata = 32'h0;
    end

    // Source enables
    d.pll_en    = (q.mode == MODE_XTAL_PLL);
    d.start_dly = (q.mode == MODE_LP_XTAL) || (q.mode == MODE_XT_XTAL) ||
                  (q.mode == MODE_FAST_XTAL) || (q.mode == MODE_XTAL_PLL);
    d.fast_en   = int_mode && (q.ifs != `OSC_IFS_SLOW);
    d.slow_en   = int_mode || PWRT_EN || FSCM_EN || WDT_EN || TWO_SPEED_EN;

    // Fast oscillator: accumulator carry toggles an 8 MHz level
    if (nco_run) begin
      d.acc = acc_sum[31:0];
      if (acc_sum[32]) begin
        d.fast_clk = !q.fast_clk;
      end
    end else begin
      d.acc      = 32'h0;
      d.fast_clk = 1'b0;
    end

    // New tune lands on a slow edge: one slow cycle, well inside 1 ms for fast
    d.slow_prev = slow_clk;
    if ((slow_clk && !q.slow_prev) || !nco_run) begin
      d.tune_app = q.tune;
    end

    // PLL: phase steps by 2*mult a cycle and wraps at the period, so no rounding drift
    d.in_prev = pin_clk;
    if (pin_clk && !q.in_prev) begin
      d.per     = q.per_cnt;
      d.per_cnt = 8'h0;
    end else if (q.per_cnt != 8'hff) begin
      d.per_cnt = q.per_cnt + 8'h01;
    end
    if (!q.pll_en) begin
      d.pll_clk = 1'b0;
      d.pll_cnt = 8'h0;
    end else if (q.pll_cnt >= half) begin
      d.pll_clk = !q.pll_clk;
      d.pll_cnt = q.pll_cnt - half;
    end else begin
      d.pll_cnt = q.pll_cnt + (8'h02 * `OSC_PLL_MULT);
    end

    // System clock source
    if (int_mode) begin
      d.sys_clk = int_clk;
    end else if (q.mode == MODE_XTAL_PLL) begin
      d.sys_clk = q.pll_clk;
    end else begin
      d.sys_clk = pin_clk;
    end

    // Output pin reuse
    d.co_o    = 1'b0;
    d.co_oe_n = 1'b1;
    d.pa6_in  = 1'b0;
    d.ci_o    = 1'b0;
    d.ci_oe_n = 1'b1;
    d.pa7_in  = 1'b0;
    case (q.mode)
      MODE_EXT_CLK, MODE_RC, MODE_INT_CLKOUT: begin
        d.co_o    = fosc4;
        d.co_oe_n = 1'b0;
      end
      MODE_EXT_IO, MODE_RC_IO, MODE_INT_DUAL: begin
        d.co_o    = PA6_OUT;
        d.co_oe_n = !PA6_OE;
        d.pa6_in  = pin_s[1];
      end
      default: begin
        d.co_o    = 1'b0;
      end
    endcase
    if (int_mode) begin
      d.ci_o    = PA7_OUT;
      d.ci_oe_n = !PA7_OE;
      d.pa7_in  = pin_s[0];
    end
  end

  // Internal block output select
  always_comb begin
    case (q.ifs)
      `OSC_IFS_FAST: int_clk = q.fast_clk;
      `OSC_IFS_SLOW: int_clk = slow_clk;
      default:       int_clk = post_bus.count[3'(3'h6 - q.ifs)];
    endcase
  end

  // ==========================================================================
  // Registers; the mode straps are caught while reset is held
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      q      <= '0;
      q.tune <= `OSC_TUNE_RST;
      q.ifs  <= `OSC_IFS_RST;
      case (OSC_MODE_CFG)
        4'h0:    q.mode <= MODE_LP_XTAL;
        4'h1:    q.mode <= MODE_XT_XTAL;
        4'h2:    q.mode <= MODE_FAST_XTAL;
        4'h3:    q.mode <= MODE_RC;
        4'h5:    q.mode <= MODE_EXT_IO;
        4'h6:    q.mode <= MODE_XTAL_PLL;
        4'h7:    q.mode <= MODE_RC_IO;
        4'h8:    q.mode <= MODE_INT_CLKOUT;
        4'h9:    q.mode <= MODE_INT_DUAL;
        default: q.mode <= MODE_EXT_CLK;
      endcase
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // Outputs
  assign HRDATA         = q.rdata;
  assign HREADYOUT      = 1'b1;
  assign HRESP          = 1'b0;
  assign CLKIN_O        = q.ci_o;
  assign CLKIN_OE_N     = q.ci_oe_n;
  assign CLKOUT_O       = q.co_o;
  assign CLKOUT_OE_N    = q.co_oe_n;
  assign PA6_IN         = q.pa6_in;
  assign PA7_IN         = q.pa7_in;
  assign SYS_CLK        = q.sys_clk;
  assign PLL_EN         = q.pll_en;
  assign START_DELAY_EN = q.start_dly;
  assign FAST_OSC_EN    = q.fast_en;
  assign SLOW_OSC_EN    = q.slow_en;

  // ==========================================================================
  // Checks
  logic [15:0] pend_cnt;
  logic        rd_tune;
  logic        live_q;

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      pend_cnt <= 16'h0;
      rd_tune  <= 1'b0;
      live_q   <= 1'b0;
    end else begin
      live_q  <= 1'b1;
      rd_tune <= addr_ok && !HWRITE && (HADDR == `OSC_REG_TUNE);
      if (q.tune_app == q.tune) begin
        pend_cnt <= 16'h0;
      end else if (pend_cnt != 16'hffff) begin
        pend_cnt <= pend_cnt + 16'h0001;
      end
    end
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N || !live_q); // Release edge still shows reset-time state

  property p_pll_toggle;
    PLL_EN && (q.pll_cnt >= half) |=> q.pll_clk != $past(q.pll_clk);
  endproperty
  a_pll_toggle: assert property (p_pll_toggle)
    else $error("PLL output missed its toggle");

  property p_pll_only;
    ##1 (PLL_EN == (q.mode == MODE_XTAL_PLL));
  endproperty
  a_pll_only: assert property (p_pll_only)
    else $error("PLL enable disagrees with mode");

  property p_no_start_delay;
    (q.mode == MODE_EXT_CLK) || (q.mode == MODE_EXT_IO) |-> ##1 !START_DELAY_EN;
  endproperty
  a_no_start_delay: assert property (p_no_start_delay)
    else $error("Start delay requested for external clock");

  property p_ec_clkout;
    (q.mode == MODE_EXT_CLK) ##1 1'b1 |-> !CLKOUT_OE_N && (CLKOUT_O == $past(fosc4));
  endproperty
  a_ec_clkout: assert property (p_ec_clkout)
    else $error("Clock out pin not showing Fosc/4");

  property p_rc_clkout;
    (q.mode == MODE_RC) ##1 1'b1 |-> !CLKOUT_OE_N && (CLKOUT_O == $past(fosc4));
  endproperty
  a_rc_clkout: assert property (p_rc_clkout)
    else $error("Clock out pin not showing Fosc/4 in RC mode");

  property p_reuse_six;
    ((q.mode == MODE_EXT_IO) || (q.mode == MODE_RC_IO)) ##1 1'b1
      |-> (CLKOUT_OE_N == !$past(PA6_OE)) && (PA6_IN == $past(pin_s[1]));
  endproperty
  a_reuse_six: assert property (p_reuse_six)
    else $error("Out pin not acting as port bit six");

  property p_dual_pins;
    (q.mode == MODE_INT_DUAL) ##1 1'b1
      |-> (CLKIN_OE_N == !$past(PA7_OE)) && (CLKOUT_OE_N == !$past(PA6_OE));
  endproperty
  a_dual_pins: assert property (p_dual_pins)
    else $error("Dual pin mode pins not reused");

  property p_fast_en;
    ##1 (FAST_OSC_EN == $past(int_mode && (q.ifs != `OSC_IFS_SLOW)));
  endproperty
  a_fast_en: assert property (p_fast_en)
    else $error("Fast oscillator enable wrong");

  property p_slow_en;
    (PWRT_EN || WDT_EN) |=> SLOW_OSC_EN;
  endproperty
  a_slow_en: assert property (p_slow_en)
    else $error("Slow oscillator not enabled by feature");

  property p_direct_fast;
    int_mode && (q.ifs == `OSC_IFS_FAST) |=> (q.sys_clk == $past(q.fast_clk));
  endproperty
  a_direct_fast: assert property (p_direct_fast)
    else $error("Direct fast selection not on system clock");

  property p_tune_upper;
    rd_tune |-> (HRDATA[31:`OSC_TUNE_W] == '0);
  endproperty
  a_tune_upper: assert property (p_tune_upper)
    else $error("Tune register upper bits not zero");

  property p_slow_settle;
    32'(pend_cnt) <= SLOW_SETTLE_CYC;
  endproperty
  a_slow_settle: assert property (p_slow_settle)
    else $error("Slow oscillator retune too slow");

  property p_fast_settle;
    32'(pend_cnt) <= FAST_SETTLE_CYC;
  endproperty
  a_fast_settle: assert property (p_fast_settle)
    else $error("Fast oscillator retune too slow");

endmodule

// [osc_map.svh]
// Offsets, field positions, reset values and timing counts of the clock control block.
// Assumes inclusion by bare name from the package and the top module.
`ifndef OSC_MAP_SVH
`define OSC_MAP_SVH

// ==========================================================================
// Register byte addresses on the AHB-Lite slave
`define OSC_REG_TUNE        32'h0000_0000
`define OSC_REG_CTRL        32'h0000_0004
`define OSC_REG_STAT        32'h0000_0008

// ==========================================================================
// Field positions and reset values
`define OSC_TUNE_W          6
`define OSC_TUNE_RST        6'h00
`define OSC_CTRL_IFS_LSB    4
`define OSC_IFS_RST         3'h0
`define OSC_IFS_FAST        3'h7
`define OSC_IFS_SLOW        3'h0

// ==========================================================================
// Clock model figures
`define OSC_MCLK_NS         20
`define OSC_NCO_BASE        32'h51eb_851f
`define OSC_NCO_STEP        32'h0029_f16b
`define OSC_POST_W          8
`define OSC_FOSC_DIV_W      2
`define OSC_PLL_MULT        8'h04
`define OSC_SLOW_CYCLES     8
`define OSC_SLOW_CYCLE_NS   32000
`define OSC_FAST_SETTLE_NS  1000000

`endif

// [osc_pkg.sv]
// Types shared by the clock control block: oscillator modes and the state record.
// Assumes osc_map.svh is on the include path.
`include "osc_map.svh"

package osc_pkg;

  // ==========================================================================
  // Oscillator modes as coded by the four configuration bits
  typedef enum logic [3:0] {
    MODE_LP_XTAL    = 4'b0000,
    MODE_XT_XTAL    = 4'b0001,
    MODE_FAST_XTAL  = 4'b0010,
    MODE_RC         = 4'b0011,
    MODE_EXT_CLK    = 4'b0100,
    MODE_EXT_IO     = 4'b0101,
    MODE_XTAL_PLL   = 4'b0110,
    MODE_RC_IO      = 4'b0111,
    MODE_INT_CLKOUT = 4'b1000,
    MODE_INT_DUAL   = 4'b1001
  } osc_mode_t;

  // ==========================================================================
  // Whole state of the top module
  typedef struct packed {
    osc_mode_t                mode;
    logic [`OSC_TUNE_W-1:0]   tune;
    logic [`OSC_TUNE_W-1:0]   tune_app;
    logic [2:0]               ifs;
    logic [31:0]              acc;
    logic                     fast_clk;
    logic                     slow_prev;
    logic [7:0]               per_cnt;
    logic [7:0]               per;
    logic [7:0]               pll_cnt;
    logic                     pll_clk;
    logic                     in_prev;
    logic                     sys_clk;
    logic                     fast_en;
    logic                     slow_en;
    logic                     pll_en;
    logic                     start_dly;
    logic                     wr_tune;
    logic                     wr_ctrl;
    logic [31:0]              rdata;
    logic                     co_o;
    logic                     co_oe_n;
    logic                     ci_o;
    logic                     ci_oe_n;
    logic                     pa6_in;
    logic                     pa7_in;
  } ctl_state_t;

endpackage

// [pin_sync.sv]
// Three-stage synchroniser for pin inputs.
// Assumes pins are asynchronous to clk; output moves once stages two and three agree.
module pin_sync #(
  parameter int W = 2
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] val;
  } sync_state_t;

  sync_state_t s_q;
  sync_state_t s_d;

  always_comb begin
    s_d     = s_q;
    s_d.s1  = async_i;
    s_d.s2  = s_q.s1;
    s_d.s3  = s_q.s2;
    // Per bit: follow when the two later stages agree, else hold
    s_d.val = (s_q.s2 & s_q.s3) | (s_q.val & (s_q.s2 | s_q.s3));
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_o = s_q.val;

endmodule

// [tb.sv]
// Self-checking bench of osc_control: register bus, modes, pin reuse, clocks.
// Assumes osc_map.svh on the include path and clk_source as the external clock.
`include "osc_map.svh"

module tb import osc_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Signals
  logic        mclk = 1'b0;
  logic        rst_n, hsel, hwrite, hreadyout, hresp, src_run, src_clk;
  logic [3:0]  mode_cfg, feat;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, sys_n, out_n;
  logic [15:0] src_half;
  logic        pa6_out, pa6_oe, pa7_out, pa7_oe, ext6, ext7;
  logic        clkin_o, clkin_oe_n, clkout_o, clkout_oe_n, pa6_in, pa7_in;
  logic        sys_clk, pll_en, sdly, fast_en, slow_en;
  logic        sys_p = 1'b0;
  logic        out_p = 1'b0;
  int          errors, n_checks;
  wire         clkin_pin = !clkin_oe_n ? clkin_o : (src_run ? src_clk : ext7);
  wire         clkout_pin = !clkout_oe_n ? clkout_o : ext6;

  always #10 mclk = ~mclk;

  clk_source src (.run(src_run), .half_ns(src_half), .clk_o(src_clk));

  osc_control #(.SLOW_SETTLE_CYC(2000), .FAST_SETTLE_CYC(2000)) dut (
    .MCLK(mclk), .RST_N(rst_n), .OSC_MODE_CFG(mode_cfg), .PWRT_EN(feat[0]),
    .FSCM_EN(feat[1]), .WDT_EN(feat[2]), .TWO_SPEED_EN(feat[3]), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
    .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
    .CLKIN_I(clkin_pin), .CLKIN_O(clkin_o), .CLKIN_OE_N(clkin_oe_n),
    .CLKOUT_I(clkout_pin), .CLKOUT_O(clkout_o), .CLKOUT_OE_N(clkout_oe_n),
    .PA6_OUT(pa6_out), .PA6_OE(pa6_oe), .PA6_IN(pa6_in), .PA7_OUT(pa7_out),
    .PA7_OE(pa7_oe), .PA7_IN(pa7_in), .SYS_CLK(sys_clk), .PLL_EN(pll_en),
    .START_DELAY_EN(sdly), .FAST_OSC_EN(fast_en), .SLOW_OSC_EN(slow_en));

  // Rising edges of the modelled system clock and of the clock-out pin
  always @(posedge mclk) begin
    sys_p <= sys_clk;
    out_p <= clkout_o;
    if (sys_clk && !sys_p) sys_n <= sys_n + 32'h1;
    if (clkout_o && !out_p) out_n <= out_n + 32'h1;
  end

  // ==========================================================================
  // Helpers
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic near(input logic [31:0] got, input int exp, input int tol);
    check(32'(got + tol >= exp && got <= exp + tol), 32'h1);
  endtask

  task automatic wait_ready;
    int k;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 64);
    if (hreadyout !== 1'b1) begin
      errors++;
      print_verdict();
    end
  endtask

  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready();
    r = hrdata;
    check(32'(hresp), 32'h0);
  endtask

  task automatic set_mode(input logic [3:0] m);
    rst_n <= 1'b0;
    mode_cfg <= m;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (2) @(posedge mclk);
  endtask

  task automatic measure(input int cyc, output logic [31:0] s, output logic [31:0] o);
    logic [31:0] s0, o0;
    s0 = sys_n;
    o0 = out_n;
    repeat (cyc) @(posedge mclk);
    s = sys_n - s0;
    o = out_n - o0;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_regs;
    logic [31:0] r;
    set_mode(MODE_EXT_CLK);
    bus(1'b0, `OSC_REG_TUNE, 32'h0, r); check(r, 32'h0);
    bus(1'b1, `OSC_REG_TUNE, 32'hffff_ffe0, r);
    bus(1'b0, `OSC_REG_TUNE, 32'h0, r); check(r, 32'h0000_0020);
    bus(1'b1, `OSC_REG_CTRL, 32'hffff_ff70, r);
    bus(1'b0, `OSC_REG_CTRL, 32'h0, r); check(r, 32'h0000_0070);
    bus(1'b1, 32'h0000_0010, 32'hffff_ffff, r);
    bus(1'b0, 32'h0000_0010, 32'h0, r); check(r, 32'h0);
    $display("test regs done");
  endtask

  task automatic t_modes;
    logic [31:0] r;
    for (int m = 0; m < 10; m++) begin
      set_mode(4'(m));
      bus(1'b0, `OSC_REG_STAT, 32'h0, r); check(32'(r[3:0]), 32'(m));
      check(32'(pll_en), 32'(m == 6));
      check(32'(r[4]), 32'(m == 6));
      check(32'(sdly), 32'(m < 3 || m == 6));
      check(32'(slow_en), 32'(m >= 8));
      check(32'(fast_en), 32'h0);
    end
    $display("test modes done");
  endtask

  task automatic t_features;
    set_mode(MODE_EXT_CLK);
    for (int i = 0; i < 4; i++) begin
      feat <= 4'(1 << i);
      repeat (3) @(posedge mclk);
      check(32'(slow_en), 32'h1);
      feat <= 4'h0;
      repeat (3) @(posedge mclk);
      check(32'(slow_en), 32'h0);
    end
    $display("test features done");
  endtask

  task automatic t_fosc4;
    osc_mode_t   ml[3] = '{MODE_EXT_CLK, MODE_RC, MODE_INT_CLKOUT};
    logic [31:0] r, s, o;
    src_half <= 16'd100;
    for (int i = 0; i < 3; i++) begin
      src_run <= (i < 2);
      set_mode(ml[i]);
      bus(1'b1, `OSC_REG_CTRL, 32'h0000_0070, r);
      repeat (300) @(posedge mclk);
      measure(2048, s, o);
      check(32'(s > 100), 32'h1);
      near(o, int'(s) / 4, 1);
      check(32'(clkout_oe_n), 32'h0);
    end
    $display("test clock out done");
  endtask

  task automatic t_pins;
    osc_mode_t ml[4] = '{MODE_EXT_IO, MODE_RC_IO, MODE_INT_CLKOUT, MODE_INT_DUAL};
    logic      h6, h7;
    src_run <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      h6 = (i != 2);
      h7 = (i >= 2);
      set_mode(ml[i]);
      {pa6_oe, pa6_out, pa7_oe, pa7_out} <= 4'hf;
      repeat (3) @(posedge mclk);
      if (h6) check(32'({clkout_oe_n, clkout_o}), 32'h1);
      if (h7) check(32'({clkin_oe_n, clkin_o}), 32'h1);
      {pa6_oe, pa7_oe, ext6, ext7} <= 4'h3;
      repeat (8) @(posedge mclk);
      check(32'({pa6_in, pa7_in}), 32'({h6, h7}));
      if (h7) check(32'(clkin_oe_n), 32'h1);
      {ext6, ext7} <= 2'b00;
      repeat (8) @(posedge mclk);
      check(32'({pa6_in, pa7_in}), 32'h0);
    end
    $display("test pins done");
  endtask

  task automatic t_pll;
    logic [31:0] s, o;
    src_half <= 16'd500;
    src_run <= 1'b1;
    set_mode(MODE_XTAL_PLL);
    repeat (1000) @(posedge mclk);
    measure(4096, s, o);
    near(s, 328, 8);
    $display("test multiplier done");
  endtask

  task automatic t_select;
    logic [31:0] r, s, o;
    src_run <= 1'b0;
    set_mode(MODE_INT_DUAL);
    for (int c = 7; c >= 0; c--) begin
      bus(1'b1, `OSC_REG_CTRL, 32'(c << 4), r);
      repeat (300) @(posedge mclk);
      measure(c ? 2048 : 16384, s, o);
      near(s, c ? (32768 >> (7 - c)) / 100 : 10, 3);
      check(32'(fast_en), 32'(c != 0));
      check(32'(slow_en), 32'h1);
    end
    $display("test select done");
  endtask

  task automatic t_tune;
    logic [5:0]  tv[3] = '{6'h00, 6'h1f, 6'h20};
    logic [31:0] f[3];
    logic [31:0] r, o;
    set_mode(MODE_INT_DUAL);
    bus(1'b1, `OSC_REG_CTRL, 32'h0000_0070, r);
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, `OSC_REG_TUNE, 32'(tv[i]), r);
      // Frequency shifts without any flag, so the bench waits out the bound
      repeat (2000) @(posedge mclk);
      measure(4096, f[i], o);
    end
    check(32'(f[1] > f[0] && f[0] > f[2]), 32'h1);
    near((f[1] - f[0]) * 32, int'((f[0] - f[2]) * 31), 130);
    $display("test tuning done");
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    {rst_n, hsel, hwrite, src_run, pa6_out, pa6_oe, pa7_out, pa7_oe} = 8'h00;
    {ext6, ext7} = 2'b00;
    mode_cfg = 4'h0;
    feat = 4'h0;
    htrans = 2'b00;
    haddr = 32'h0;
    hwdata = 32'h0;
    src_half = 16'd100;
    sys_n = 32'h0;
    out_n = 32'h0;
    errors = 0;
    n_checks = 0;
    repeat (8) @(posedge mclk);
    t_regs();
    t_modes();
    t_features();
    t_fosc4();
    t_pins();
    t_pll();
    t_select();
    t_tune();
    print_verdict();
  end
endmodule
